/* logic/dfm_top.sv */
// Fault flag collection, pin readback, access monitor and status word.
// Assumes monitor inputs come from logic on this clock; pins and the
// diagnostic oscillator come from outside and are synchronised here.
`timescale 1ns/100ps
`default_nettype none
module dfm_top
  import dfm_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  output logic      [ADDR_W-1:0] reg_raddr,
  input  wire logic              diagnostic_oscillator,
  input  wire logic              image_wr,
  input  wire logic [3:0]        image_index,
  input  wire logic [15:0]       image_data,
  input  wire logic [7:0]        supply_fault_n,
  input  wire logic [3:0]        timing_fault_n,
  input  wire logic [PIN_N-1:0]  pin_in,
  output logic      [PIN_N-1:0]  pin_out,
  output logic      [PIN_N-1:0]  pin_oe,
  input  wire logic              frame_start,
  output logic      [15:0]       status_word
);

  typedef struct packed {
    logic              osc_s1;
    logic              osc_s2;
    logic              osc_s3;
    logic [PIN_N-1:0]  pin_s1;
    logic [PIN_N-1:0]  pin_s2;
    logic              reset_occurred_indicator_n;
    logic              access_fail_n;
    logic              supply_summary_fail_n;
    logic              timing_source_summary_fail_n;
    logic              logic_summary_fail_n;
    logic [7:0]        supply_st;
    logic [3:0]        timing_st;
    logic [1:0]        logic_st;
    logic [7:0]        supply_msk;
    logic [3:0]        timing_msk;
    logic [1:0]        logic_msk;
    logic [PIN_N-1:0]  pin_dir;
    logic [PIN_N-1:0]  pin_drv;
    logic [15:0]       rdata;
    logic [ADDR_W-1:0] raddr;
    logic [15:0]       status_word;
  } dfm_state_t;

  dfm_state_t s_q, s_d;

  logic              osc_step;
  logic              image_bad;
  logic [15:0]       upper_status;
  logic [2*PIN_N-1:0] pin_readback_value;
  logic              pin_mismatch;

  dfm_image_crc u_image_crc (
    .clock       (clock),
    .rst         (rst),
    .step        (osc_step),
    .image_wr    (image_wr),
    .image_index (image_index),
    .image_data  (image_data),
    .check_bad   (image_bad)
  );

  // Edge found on the second and third stage only, never the first
  assign osc_step = s_q.osc_s2 & ~s_q.osc_s3;

  // Readback field per pin: {drive mismatch, sensed level}; zero when an input
  always_comb begin
    pin_readback_value = '0;
    pin_mismatch       = 1'b0;
    for (int p = 0; p < PIN_N; p++) begin
      if (s_q.pin_dir[p]) begin
        pin_readback_value[2*p]   = s_q.pin_s2[p];
        pin_readback_value[2*p+1] = s_q.pin_s2[p] ^ s_q.pin_drv[p];
        pin_mismatch = pin_mismatch | (s_q.pin_s2[p] ^ s_q.pin_drv[p]);
      end
    end
  end

  always_comb begin
    upper_status                 = 16'h0000;
    upper_status[RESET_OCC_BIT]  = s_q.reset_occurred_indicator_n;
    upper_status[ACCESS_BIT]     = s_q.access_fail_n;
    upper_status[SUPPLY_SUM_BIT] = s_q.supply_summary_fail_n;
    upper_status[TIMING_SUM_BIT] = s_q.timing_source_summary_fail_n;
    upper_status[LOGIC_SUM_BIT]  = s_q.logic_summary_fail_n;
  end

  always_comb begin
    logic [1:0]  lg_evt_n;
    logic        sup_hit;
    logic        tim_hit;
    logic        lg_hit;
    logic        wr_sm;
    lg_evt_n = LOGIC_RST;
    sup_hit  = 1'b0;
    tim_hit  = 1'b0;
    lg_hit   = 1'b0;
    wr_sm    = 1'b0;
    s_d      = s_q;

    s_d.osc_s1 = diagnostic_oscillator;
    s_d.osc_s2 = s_q.osc_s1;
    s_d.osc_s3 = s_q.osc_s2;
    s_d.pin_s1 = pin_in;
    s_d.pin_s2 = s_q.pin_s1;

    // Plain registers
    if (reg_wr) begin
      case (reg_addr)
        SUPPLY_MSK_ADDR: s_d.supply_msk = reg_wdata[7:0];
        CLOCK_MSK_ADDR:  s_d.timing_msk = reg_wdata[3:0];
        LOGIC_MSK_ADDR:  s_d.logic_msk  = reg_wdata[1:0];
        PIN_DIR_ADDR:    s_d.pin_dir    = reg_wdata[PIN_N-1:0];
        PIN_OUT_ADDR:    s_d.pin_drv    = reg_wdata[PIN_N-1:0];
        default:         ;
      endcase
    end

    // Detailed flags: write one restores, a new fault wins over the clear
    if (reg_wr && reg_addr == SUPPLY_ST_ADDR) begin
      s_d.supply_st = s_q.supply_st | reg_wdata[7:0];
    end
    if (reg_wr && reg_addr == CLOCK_ST_ADDR) begin
      s_d.timing_st = s_q.timing_st | reg_wdata[3:0];
    end
    if (reg_wr && reg_addr == LOGIC_ST_ADDR) begin
      s_d.logic_st = s_q.logic_st | reg_wdata[1:0];
    end
    // Image mismatch only lowers its flag; the device carries on
    lg_evt_n[IMAGE_BIT]   = ~image_bad;
    lg_evt_n[PIN_CHK_BIT] = ~pin_mismatch;
    s_d.supply_st = s_d.supply_st & supply_fault_n;
    s_d.timing_st = s_d.timing_st & timing_fault_n;
    s_d.logic_st  = s_d.logic_st & lg_evt_n;

    // Masked flags still report locally but stay out of the summary
    sup_hit = |(~s_d.supply_st & ~s_q.supply_msk);
    tim_hit = |(~s_d.timing_st & ~s_q.timing_msk);
    lg_hit  = |(~s_d.logic_st & ~s_q.logic_msk);

    // Summary clear is refused while any detailed flag is still low
    wr_sm = reg_wr && (reg_addr == STATUS_MSB_ADDR);
    if (wr_sm && reg_wdata[SUPPLY_SUM_BIT] && (&s_q.supply_st)) begin
      s_d.supply_summary_fail_n = 1'b1;
    end
    if (wr_sm && reg_wdata[TIMING_SUM_BIT] && (&s_q.timing_st)) begin
      s_d.timing_source_summary_fail_n = 1'b1;
    end
    if (wr_sm && reg_wdata[LOGIC_SUM_BIT] && (&s_q.logic_st)) begin
      s_d.logic_summary_fail_n = 1'b1;
    end
    if (wr_sm && reg_wdata[RESET_OCC_BIT]) begin
      s_d.reset_occurred_indicator_n = 1'b1;
    end
    if (wr_sm && reg_wdata[ACCESS_BIT]) begin
      s_d.access_fail_n = 1'b1;
    end
    if (sup_hit) begin
      s_d.supply_summary_fail_n = 1'b0;
    end
    if (tim_hit) begin
      s_d.timing_source_summary_fail_n = 1'b0;
    end
    if (lg_hit) begin
      s_d.logic_summary_fail_n = 1'b0;
    end

    // Only the top of the address space faults; holes below it are quiet
    if ((reg_wr || reg_rd) && reg_addr >= ADDR_LIMIT) begin
      s_d.access_fail_n = 1'b0;
    end

    // Read data stands for one cycle only
    s_d.rdata = 16'h0000;
    s_d.raddr = '0;
    if (reg_rd) begin
      s_d.raddr = reg_addr;
      case (reg_addr)
        STATUS_MSB_ADDR: s_d.rdata = upper_status;
        SUPPLY_ST_ADDR:  s_d.rdata = {8'h00, s_q.supply_st};
        CLOCK_ST_ADDR:   s_d.rdata = {12'h000, s_q.timing_st};
        LOGIC_ST_ADDR:   s_d.rdata = {14'h0000, s_q.logic_st};
        SUPPLY_MSK_ADDR: s_d.rdata = {8'h00, s_q.supply_msk};
        CLOCK_MSK_ADDR:  s_d.rdata = {12'h000, s_q.timing_msk};
        LOGIC_MSK_ADDR:  s_d.rdata = {14'h0000, s_q.logic_msk};
        PIN_DIR_ADDR:    s_d.rdata = {12'h000, s_q.pin_dir};
        PIN_OUT_ADDR:    s_d.rdata = {12'h000, s_q.pin_drv};
        PIN_RB_ADDR:     s_d.rdata = {8'h00, pin_readback_value};
        default: begin
          s_d.rdata = 16'h0000;
          s_d.raddr = '0;
        end
      endcase
    end

    // Snapshot at frame start so the word cannot change mid-frame
    if (frame_start) begin
      s_d.status_word = upper_status;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_q <= '{
        osc_s1: 1'b0, osc_s2: 1'b0, osc_s3: 1'b0,
        pin_s1: PIN_RST, pin_s2: PIN_RST,
        reset_occurred_indicator_n: 1'b0,
        access_fail_n: 1'b1,
        supply_summary_fail_n: 1'b1,
        timing_source_summary_fail_n: 1'b1,
        logic_summary_fail_n: 1'b1,
        supply_st: SUPPLY_RST, timing_st: TIMING_RST, logic_st: LOGIC_RST,
        supply_msk: MASK_RST, timing_msk: MASK_RST[3:0], logic_msk: MASK_RST[1:0],
        pin_dir: PIN_RST, pin_drv: PIN_RST,
        rdata: 16'h0000, raddr: 9'h000, status_word: 16'h0000
      };
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata   = s_q.rdata;
  assign reg_raddr   = s_q.raddr;
  assign pin_out     = s_q.pin_drv;
  assign pin_oe      = s_q.pin_dir;
  assign status_word = s_q.status_word;

endmodule : dfm_top
`default_nettype wire

/* logic/dfm_pkg.sv */
// Constants, register map and field layout of the digital fault monitor aggregator.
// Assumes one 125 MHz clock domain and a plain address/strobe register port.
//
// Function
// - Memory-image check always running, no enable
// - Check mismatch drives image fail flag low
// - Mismatch only sets flag, nothing else
// - One image word per oscillator period
// - Writing one restores image fail flag
// - Output pins sensed by separate receiver
// - Sensed level shown in two-bit field
// - Access at address FFh or above faults
// - Unassigned addresses below FFh raise nothing
// - Missing register reads zero data, address
// - Each monitor owns an active-low flag
// - Reset and comm flags in upper status
// - Upper status sent at frame start
// - Any unmasked detailed fault pulls combined flag low
// - Combined clears only after detailed cleared
// - Masked flag stays local, not combined
package dfm_pkg;

  localparam int ADDR_W = 9;
  localparam int DATA_W = 16;

  // Register offsets
  localparam logic [8:0] STATUS_MSB_ADDR = 9'h001;
  localparam logic [8:0] SUPPLY_ST_ADDR  = 9'h002;
  localparam logic [8:0] CLOCK_ST_ADDR   = 9'h003;
  localparam logic [8:0] LOGIC_ST_ADDR   = 9'h004;
  localparam logic [8:0] SUPPLY_MSK_ADDR = 9'h005;
  localparam logic [8:0] CLOCK_MSK_ADDR  = 9'h006;
  localparam logic [8:0] LOGIC_MSK_ADDR  = 9'h007;
  localparam logic [8:0] PIN_DIR_ADDR    = 9'h008;
  localparam logic [8:0] PIN_OUT_ADDR    = 9'h009;
  localparam logic [8:0] PIN_RB_ADDR     = 9'h00A;
  localparam logic [8:0] ADDR_LIMIT      = 9'h0FF;

  // Upper status bit positions
  localparam int RESET_OCC_BIT  = 15;
  localparam int ACCESS_BIT     = 14;
  localparam int SUPPLY_SUM_BIT = 13;
  localparam int TIMING_SUM_BIT = 12;
  localparam int LOGIC_SUM_BIT  = 11;

  // Group widths and logic status bits
  localparam int SUPPLY_N    = 8;
  localparam int TIMING_N    = 4;
  localparam int LOGIC_N     = 2;
  localparam int PIN_N       = 4;
  localparam int IMAGE_BIT   = 0;
  localparam int PIN_CHK_BIT = 1;

  // Reset values
  localparam logic [7:0] SUPPLY_RST = 8'hFF;
  localparam logic [3:0] TIMING_RST = 4'hF;
  localparam logic [1:0] LOGIC_RST  = 2'h3;
  localparam logic [7:0] MASK_RST   = 8'h00;
  localparam logic [3:0] PIN_RST    = 4'h0;

  // Memory image: last word holds the reference check value
  localparam int          IMAGE_WORDS = 16;
  localparam logic [3:0]  IMAGE_LAST  = 4'hF;
  localparam logic [15:0] CRC_SEED    = 16'h0000;
  localparam logic [15:0] CRC_POLY    = 16'h1021;
  localparam logic [15:0] IMAGE_RST   = 16'h0000;

  // Worst-case detection latency in oscillator periods
  localparam int MEMORY_CHECK_LATENCY = 2 * IMAGE_WORDS;

endpackage : dfm_pkg

/* logic/dfm_image_crc.sv */
// Serial check engine over the internal memory image.
// Assumes one step pulse per diagnostic oscillator period from the parent.
`timescale 1ns/100ps
`default_nettype none
module dfm_image_crc
  import dfm_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        step,
  input  wire logic        image_wr,
  input  wire logic [3:0]  image_index,
  input  wire logic [15:0] image_data,
  output logic             check_bad
);

  typedef struct packed {
    logic [IMAGE_WORDS-1:0][15:0] mem;
    logic [3:0]                   idx;
    logic [15:0]                  crc;
    logic                         bad;
  } dfm_crc_st_t;

  dfm_crc_st_t s_q, s_d;

  function automatic logic [15:0] crc_word(input logic [15:0] c, input logic [15:0] w);
    logic [15:0] r;
    r = c;
    for (int i = 15; i >= 0; i--) begin
      r = (r[15] ^ w[i]) ? ({r[14:0], 1'b0} ^ CRC_POLY) : {r[14:0], 1'b0};
    end
    return r;
  endfunction : crc_word

  always_comb begin
    s_d     = s_q;
    s_d.bad = 1'b0;
    if (image_wr) begin
      s_d.mem[image_index] = image_data;
    end
    // No enable: the pass restarts forever
    if (step) begin
      if (s_q.idx == IMAGE_LAST) begin
        s_d.bad = (s_q.crc != s_q.mem[IMAGE_LAST]);
        s_d.crc = CRC_SEED;
        s_d.idx = 4'h0;
      end else begin
        s_d.crc = crc_word(s_q.crc, s_q.mem[s_q.idx]);
        s_d.idx = s_q.idx + 4'h1;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_q <= '{mem: {IMAGE_WORDS{IMAGE_RST}}, idx: 4'h0, crc: CRC_SEED, bad: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign check_bad = s_q.bad;

endmodule : dfm_image_crc
`default_nettype wire

/* bench/dfm_top_assertions.sv */
// Checker for the fault monitor top: bus, flags, pins and status word.
// Assumes it is bound to dfm_top and sees only that module's ports.
`timescale 1ns/100ps
`default_nettype none
module dfm_checker
  import dfm_pkg::*;
(
  input wire logic              clock,
  input wire logic              rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic [ADDR_W-1:0] reg_raddr,
  input wire logic [7:0]        supply_fault_n,
  input wire logic [3:0]        timing_fault_n,
  input wire logic [PIN_N-1:0]  pin_oe,
  input wire logic              frame_start,
  input wire logic [15:0]       status_word
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  property p_idle_zero;
    !reg_rd |=> reg_rdata == 16'h0000 && reg_raddr == 9'h000;
  endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("read data outside slot");
  property p_unknown_zero;
    reg_rd && reg_addr > PIN_RB_ADDR && reg_addr < ADDR_LIMIT |=>
      reg_rdata == 16'h0000 && reg_raddr == 9'h000;
  endproperty
  a_unknown_zero: assert property (p_unknown_zero) else $error("missing reg nonzero");
  property p_echo;
    reg_rd && reg_addr >= STATUS_MSB_ADDR && reg_addr <= PIN_RB_ADDR |=>
      reg_raddr == $past(reg_addr);
  endproperty
  a_echo: assert property (p_echo) else $error("read address not echoed");
  property p_frame_hold;
    !frame_start |=> $stable(status_word);
  endproperty
  a_frame_hold: assert property (p_frame_hold) else $error("status word moved");
  property p_dir_off;
    reg_rd && reg_addr == PIN_RB_ADDR && pin_oe == 4'h0 |=> reg_rdata == 16'h0000;
  endproperty
  a_dir_off: assert property (p_dir_off) else $error("readback on input pin");
  // Back-to-back form: the flag must already be low one cycle on
  property p_access;
    (reg_rd || reg_wr) && reg_addr >= ADDR_LIMIT ##1 reg_rd && reg_addr == STATUS_MSB_ADDR
      |=> !reg_rdata[ACCESS_BIT];
  endproperty
  a_access: assert property (p_access) else $error("access fault missed");
  property p_supply_latch;
    supply_fault_n != 8'hFF ##1 reg_rd && reg_addr == SUPPLY_ST_ADDR |=>
      (reg_rdata[7:0] & ~$past(supply_fault_n, 2)) == 8'h00;
  endproperty
  a_supply_latch: assert property (p_supply_latch) else $error("supply flag lost");
  property p_timing_latch;
    timing_fault_n != 4'hF ##1 reg_rd && reg_addr == CLOCK_ST_ADDR |=>
      (reg_rdata[3:0] & ~$past(timing_fault_n, 2)) == 4'h0;
  endproperty
  a_timing_latch: assert property (p_timing_latch) else $error("timing flag lost");
  property p_oe_cause;
    $changed(pin_oe) |-> $past(reg_wr && reg_addr == PIN_DIR_ADDR);
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("pin enable moved alone");
endmodule : dfm_checker

bind dfm_top dfm_checker dfm_checker_i (
  .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .reg_raddr(reg_raddr), .supply_fault_n(supply_fault_n),
  .timing_fault_n(timing_fault_n), .pin_oe(pin_oe), .frame_start(frame_start),
  .status_word(status_word)
);
`default_nettype wire

/* bench/dfm_pin_model.sv */
// Pins and diagnostic oscillator around the fault monitor.
// Assumes driven pins loop back unless flip inverts the level.
`timescale 1ns/100ps
`default_nettype none
module dfm_pin_model
  import dfm_pkg::*;
(
  input  wire logic             clock,
  input  wire logic [PIN_N-1:0] pin_out,
  input  wire logic [PIN_N-1:0] pin_oe,
  input  wire logic [PIN_N-1:0] flip,
  output logic      [PIN_N-1:0] pin_in,
  output logic                  diagnostic_oscillator
);
  logic float_q = 1'b0;
  // Released pins wander so a stale level can never pass for a reading
  always @(posedge clock) float_q <= ~float_q;
  assign pin_in = (pin_oe & (pin_out ^ flip)) | (~pin_oe & {PIN_N{float_q}});
  // Runs free, phase unrelated to the system clock
  initial begin
    diagnostic_oscillator = 1'b0;
    #5.3;
    forever #32 diagnostic_oscillator = ~diagnostic_oscillator;
  end
endmodule : dfm_pin_model
`default_nettype wire

/* bench/tb_dfm_top.sv */
// Register-level test of the fault monitor top.
// Assumes the pin model closes the pin loop and runs the oscillator.
`timescale 1ns/100ps
`default_nettype none
module tb_dfm_top;
  import dfm_pkg::*;
  localparam int OSC_CYC = 8;
  logic        clock, rst, reg_wr, reg_rd, image_wr, frame_start;
  logic [8:0]  reg_addr, reg_raddr, got_a;
  logic [15:0] reg_wdata, reg_rdata, image_data, status_word, got_d;
  logic [3:0]  image_index, timing_fault_n, pin_in, pin_out, pin_oe, flip;
  logic [7:0]  supply_fault_n;
  logic        osc;
  int          n_errors = 0;
  int          cmp_count = 0;
  int          i;

  dfm_top dfm_top_i (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_raddr(reg_raddr),
    .diagnostic_oscillator(osc), .image_wr(image_wr), .image_index(image_index),
    .image_data(image_data), .supply_fault_n(supply_fault_n),
    .timing_fault_n(timing_fault_n), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .frame_start(frame_start), .status_word(status_word));
  dfm_pin_model dfm_pin_model_i (.clock(clock), .pin_out(pin_out), .pin_oe(pin_oe),
    .flip(flip), .pin_in(pin_in), .diagnostic_oscillator(osc));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task final_report;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // Every access takes two cycles so no strobe is assigned twice in a step
  task wr(input logic [8:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
  endtask : wr
  task peek(input logic [8:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    got_d = reg_rdata;
    got_a = reg_raddr;
    @(posedge clock);
  endtask : peek
  task rd(input logic [8:0] a, input logic [15:0] e);
    peek(a);
    chk($sformatf("reg %h", a), e, got_d);
  endtask : rd
  task pulse(input logic [7:0] s, input logic [3:0] t);
    supply_fault_n <= s;
    timing_fault_n <= t;
    @(posedge clock);
    supply_fault_n <= 8'hFF;
    timing_fault_n <= 4'hF;
  endtask : pulse
  task poll_image(input logic b);
    got_d[IMAGE_BIT] = ~b;
    // Bound is two full passes plus the oscillator sync, in two-cycle reads
    for (i = 0; i < MEMORY_CHECK_LATENCY * OSC_CYC / 2 + 8 && got_d[IMAGE_BIT] !== b; i++)
      peek(LOGIC_ST_ADDR);
    if (got_d[IMAGE_BIT] !== b) begin
      $display("BAD image flag exp %b got %b", b, got_d[IMAGE_BIT]);
      n_errors++;
      final_report();
    end
  endtask : poll_image

  initial begin
    {rst, reg_wr, reg_rd, image_wr, frame_start} = 5'h10;
    {reg_addr, reg_wdata, image_data, image_index, flip} = '0;
    supply_fault_n = 8'hFF;
    timing_fault_n = 4'hF;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rd(STATUS_MSB_ADDR, 16'h7800);
    chk("reg_raddr", {7'h00, STATUS_MSB_ADDR}, {7'h00, got_a});
    rd(SUPPLY_ST_ADDR, 16'h00FF);
    rd(CLOCK_ST_ADDR, 16'h000F);
    rd(9'h0FE, 16'h0000);
    chk("reg_raddr", 16'h0000, {7'h00, got_a});
    rd(STATUS_MSB_ADDR, 16'h7800);
    wr(9'h100, 16'hFFFF);
    rd(STATUS_MSB_ADDR, 16'h3800);
    wr(STATUS_MSB_ADDR, 16'h4000);
    rd(STATUS_MSB_ADDR, 16'h7800);
    reg_addr <= ADDR_LIMIT;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_addr <= STATUS_MSB_ADDR;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk("status read", 16'h3800, reg_rdata);
    @(posedge clock);
    frame_start <= 1'b1;
    @(posedge clock);
    frame_start <= 1'b0;
    #1;
    chk("status_word", 16'h3800, status_word);
    @(posedge clock);
    wr(STATUS_MSB_ADDR, 16'h4000);
    pulse(8'hFB, 4'hF);
    rd(SUPPLY_ST_ADDR, 16'h00FB);
    rd(STATUS_MSB_ADDR, 16'h5800);
    wr(STATUS_MSB_ADDR, 16'h2000);
    rd(STATUS_MSB_ADDR, 16'h5800);
    wr(SUPPLY_ST_ADDR, 16'h0004);
    wr(STATUS_MSB_ADDR, 16'h2000);
    rd(STATUS_MSB_ADDR, 16'h7800);
    // A second frame must carry the new word, not the old snapshot
    frame_start <= 1'b1;
    @(posedge clock);
    frame_start <= 1'b0;
    #1;
    chk("status_word", 16'h7800, status_word);
    @(posedge clock);
    pulse(8'hFF, 4'h7);
    rd(CLOCK_ST_ADDR, 16'h0007);
    rd(STATUS_MSB_ADDR, 16'h6800);
    wr(CLOCK_ST_ADDR, 16'h0008);
    wr(STATUS_MSB_ADDR, 16'h1000);
    wr(SUPPLY_MSK_ADDR, 16'h0001);
    pulse(8'hFE, 4'hF);
    rd(SUPPLY_ST_ADDR, 16'h00FE);
    rd(STATUS_MSB_ADDR, 16'h7800);
    wr(SUPPLY_ST_ADDR, 16'h0001);
    rd(PIN_RB_ADDR, 16'h0000);
    wr(PIN_DIR_ADDR, 16'h000F);
    wr(PIN_OUT_ADDR, 16'h0005);
    chk("pin_out", 16'h0005, {12'h000, pin_out});
    repeat (4) @(posedge clock);
    rd(PIN_RB_ADDR, 16'h0011);
    // Drive changes pass the pin sync late, so a stale mismatch is cleared
    wr(LOGIC_ST_ADDR, 16'h0002);
    rd(LOGIC_ST_ADDR, 16'h0003);
    flip <= 4'h2;
    repeat (4) @(posedge clock);
    rd(PIN_RB_ADDR, 16'h001D);
    rd(LOGIC_ST_ADDR, 16'h0001);
    flip <= 4'h0;
    wr(PIN_DIR_ADDR, 16'h000A);
    wr(PIN_OUT_ADDR, 16'h000A);
    repeat (4) @(posedge clock);
    rd(PIN_RB_ADDR, 16'h0044);
    wr(LOGIC_ST_ADDR, 16'h0002);
    wr(STATUS_MSB_ADDR, 16'h0800);
    rd(STATUS_MSB_ADDR, 16'h7800);
    image_index <= 4'h3;
    image_data <= 16'h0001;
    image_wr <= 1'b1;
    @(posedge clock);
    image_wr <= 1'b0;
    poll_image(1'b0);
    rd(STATUS_MSB_ADDR, 16'h7000);
    rd(SUPPLY_ST_ADDR, 16'h00FF);
    chk("pin_oe", 16'h000A, {12'h000, pin_oe});
    wr(LOGIC_ST_ADDR, 16'h0001);
    poll_image(1'b0);
    // Fault keeps coming back, so the host resets the device in mid-run
    wr(STATUS_MSB_ADDR, 16'h8000);
    rd(STATUS_MSB_ADDR, 16'hF000);
    rst <= 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rd(STATUS_MSB_ADDR, 16'h7800);
    rd(LOGIC_ST_ADDR, 16'h0003);
    image_wr <= 1'b1;
    @(posedge clock);
    image_wr <= 1'b0;
    poll_image(1'b0);
    image_data <= 16'h0000;
    image_wr <= 1'b1;
    @(posedge clock);
    image_wr <= 1'b0;
    repeat (2 * MEMORY_CHECK_LATENCY * OSC_CYC) @(posedge clock);
    rd(LOGIC_ST_ADDR, 16'h0002);
    wr(LOGIC_ST_ADDR, 16'h0001);
    repeat (2 * MEMORY_CHECK_LATENCY * OSC_CYC) @(posedge clock);
    rd(LOGIC_ST_ADDR, 16'h0003);
    final_report();
  end

  initial begin
    #200000;
    n_errors++;
    final_report();
  end
endmodule : tb_dfm_top
`default_nettype wire
